/* reset_ctrl_consts.vh */
// Register offsets, field positions and reset values of the reset block
`ifndef RESET_CTRL_CONSTS_VH
`define RESET_CTRL_CONSTS_VH

`define RRQ0_OFFSET 12'h040
`define RRQ1_OFFSET 12'h044
`define RRQ_RESET 32'h0000_0000

// Implemented bits of request register 0
`define RRQ0_PWM_BIT 20
`define RRQ0_HIB_BIT 6
`define RRQ0_WDOG_BIT 3
`define RRQ0_IMPL_MASK 32'h0010_0048

// Implemented bits of request register 1
`define RRQ1_CMP2_BIT 26
`define RRQ1_CMP1_BIT 25
`define RRQ1_CMP0_BIT 24
`define RRQ1_GPC3_BIT 19
`define RRQ1_GPC0_BIT 16
`define RRQ1_TWU0_BIT 12
`define RRQ1_QENC0_BIT 8
`define RRQ1_SYNC1_BIT 5
`define RRQ1_SYNC0_BIT 4
`define RRQ1_ASYNC2_BIT 2
`define RRQ1_ASYNC0_BIT 0
`define RRQ1_IMPL_MASK 32'h070F_1137

// AHB encodings
`define HTRANS_NONSEQ 2'b10
`define HTRANS_SEQ 2'b11
`define HRESP_OKAY 1'b0

`endif

/* ahb_slave_port.v */
// AHB-Lite slave front end: captures address phase, issues strobes
`timescale 1ns/100ps
`include "reset_ctrl_consts.vh"

module ahb_slave_port #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire hready_i,
  output wire hreadyout_o,
  output wire hresp_o,
  // Register strobes
  output wire wr_en_o,
  output wire [ADDR_W-1:0] wr_addr_o,
  output wire [ADDR_W-1:0] rd_addr_o
);

  reg wr_pend_q;
  reg [ADDR_W-1:0] addr_q;
  wire take;

  // Zero wait states: write data arrives in the following data phase
  assign take = hsel_i & hready_i & htrans_i[1];
  assign hreadyout_o = 1'b1;
  assign hresp_o = `HRESP_OKAY;
  assign wr_en_o = wr_pend_q;
  assign wr_addr_o = addr_q;
  assign rd_addr_o = haddr_i[ADDR_W-1:0];

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_q <= 1'b0;
      addr_q <= {ADDR_W{1'b0}};
    end else if (hready_i) begin
      wr_pend_q <= take & hwrite_i;
      addr_q <= haddr_i[ADDR_W-1:0];
    end
  end

endmodule // ahb_slave_port

/* reset_req_reg.v */
// One masked peripheral reset request register
`timescale 1ns/100ps
`include "reset_ctrl_consts.vh"

module reset_req_reg #(
  parameter [31:0] IMPL_MASK = 32'h0000_0000
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Write port
  input wire wr_en_i,
  input wire [31:0] wdata_i,
  input wire [31:0] cap_i,
  // Contents
  output wire [31:0] value_o
);

  reg [31:0] req_q;
  wire [31:0] req_d;

  // Absent units and reserved bits never take a one
  assign req_d = wdata_i & cap_i & IMPL_MASK;
  assign value_o = req_q;

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_q <= `RRQ_RESET;
    end else if (wr_en_i) begin
      req_q <= req_d;
    end
  end

endmodule // reset_req_reg

/* peripheral_soft_reset_control.v */
// Software peripheral reset request registers behind an AHB-Lite slave
// How it works
// - Request register 0 at 0x040, resets zero
// - Register 0 writes gated by capability 1
// - Bit 20 resets the pulse-width modulator
// - Bit 6 resets the hibernation unit
// - Bit 3 resets the watchdog
// - Request register 1 at 0x044, resets zero
// - Register 1 writes gated by capability 2
// - Bits 26..24 reset comparators 2..0
// - Bits 19..16 reset timers 3..0
// - Bit 12 resets two-wire unit 0
// - Reserved bits read zero, ignore writes
// - Bit 8 resets quadrature encoder 0
// - Bits 5,4 reset sync serial 1,0
// - Bits 2..0 reset async serial 2..0
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "reset_ctrl_consts.vh"

module peripheral_soft_reset_control #(
  parameter ADDR_W = 12
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire hready_i,
  input wire [31:0] hwdata_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // Device capability words
  input wire [31:0] capability_register_1_i,
  input wire [31:0] capability_register_2_i,
  // Peripheral reset requests, active high
  output wire pwm_unit_reset_o,
  output wire hibernation_unit_reset_o,
  output wire watchdog_unit_reset_o,
  output wire comparator_0_reset_o,
  output wire comparator_1_reset_o,
  output wire comparator_2_reset_o,
  output wire gp_counter_0_reset_o,
  output wire gp_counter_1_reset_o,
  output wire gp_counter_2_reset_o,
  output wire gp_counter_3_reset_o,
  output wire two_wire_unit_0_reset_o,
  output wire quadrature_encoder_0_reset_o,
  output wire sync_serial_0_reset_o,
  output wire sync_serial_1_reset_o,
  output wire async_serial_0_reset_o,
  output wire async_serial_1_reset_o,
  output wire async_serial_2_reset_o
);

  wire wr_en;
  wire [ADDR_W-1:0] wr_addr;
  wire [ADDR_W-1:0] rd_addr;
  wire [31:0] rrq0;
  wire [31:0] rrq1;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  reg rd_take;

  function hit;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] offs;
    begin
      hit = (addr[ADDR_W-1:2] == offs[ADDR_W-1:2]);
    end
  endfunction

  ahb_slave_port #(
    .ADDR_W(ADDR_W)
  ) u_port (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .hsel_i(hsel_i),
    .haddr_i(haddr_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hsize_i(hsize_i),
    .hready_i(hready_i),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .rd_addr_o(rd_addr)
  );

  reset_req_reg #(
    .IMPL_MASK(`RRQ0_IMPL_MASK)
  ) u_rrq0 (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_en & hit(wr_addr, `RRQ0_OFFSET)),
    .wdata_i(hwdata_i),
    .cap_i(capability_register_1_i),
    .value_o(rrq0)
  );

  reset_req_reg #(
    .IMPL_MASK(`RRQ1_IMPL_MASK)
  ) u_rrq1 (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .wr_en_i(wr_en & hit(wr_addr, `RRQ1_OFFSET)),
    .wdata_i(hwdata_i),
    .cap_i(capability_register_2_i),
    .value_o(rrq1)
  );

  // reserved read zero, unmapped reads zero
  always @* begin
    rd_take = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
    rdata_d = 32'h0000_0000;
    if (hit(rd_addr, `RRQ0_OFFSET)) begin
      rdata_d = rrq0;
    end else if (hit(rd_addr, `RRQ1_OFFSET)) begin
      rdata_d = rrq1;
    end
  end

  // Read data registered in address phase, stands through data phase
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata_o = rdata_q;

  assign pwm_unit_reset_o = rrq0[`RRQ0_PWM_BIT];
  assign hibernation_unit_reset_o = rrq0[`RRQ0_HIB_BIT];
  assign watchdog_unit_reset_o = rrq0[`RRQ0_WDOG_BIT];
  assign comparator_2_reset_o = rrq1[`RRQ1_CMP2_BIT];
  assign comparator_1_reset_o = rrq1[`RRQ1_CMP1_BIT];
  assign comparator_0_reset_o = rrq1[`RRQ1_CMP0_BIT];
  assign gp_counter_3_reset_o = rrq1[`RRQ1_GPC3_BIT];
  assign gp_counter_2_reset_o = rrq1[`RRQ1_GPC0_BIT + 2];
  assign gp_counter_1_reset_o = rrq1[`RRQ1_GPC0_BIT + 1];
  assign gp_counter_0_reset_o = rrq1[`RRQ1_GPC0_BIT];
  assign two_wire_unit_0_reset_o = rrq1[`RRQ1_TWU0_BIT];
  assign quadrature_encoder_0_reset_o = rrq1[`RRQ1_QENC0_BIT];
  assign sync_serial_1_reset_o = rrq1[`RRQ1_SYNC1_BIT];
  assign sync_serial_0_reset_o = rrq1[`RRQ1_SYNC0_BIT];
  assign async_serial_2_reset_o = rrq1[`RRQ1_ASYNC2_BIT];
  assign async_serial_1_reset_o = rrq1[`RRQ1_ASYNC0_BIT + 1];
  assign async_serial_0_reset_o = rrq1[`RRQ1_ASYNC0_BIT];

endmodule // peripheral_soft_reset_control

/* reset_ctrl_checker.sv */
// Port assertions for the peripheral reset request block
`timescale 1ns/100ps
module reset_ctrl_checker (
  // Clock, reset and bus
  input wire ref_clk_i, rst_i, hsel_i, hwrite_i, hready_i,
  input wire [1:0] htrans_i,
  input wire [31:0] haddr_i, hwdata_i, hrdata_o,
  input wire hreadyout_o, hresp_o,
  // Capabilities and a sample of the requests
  input wire [31:0] capability_register_1_i, capability_register_2_i,
  input wire pwm_unit_reset_o, hibernation_unit_reset_o,
  input wire watchdog_unit_reset_o, comparator_2_reset_o,
  input wire two_wire_unit_0_reset_o, async_serial_0_reset_o
);
  reg w0_q, w1_q;
  wire take = hsel_i & hready_i & htrans_i[1];
  wire [9:0] idx = haddr_i[11:2];
  wire [31:0] g0 = hwdata_i & capability_register_1_i;
  wire [31:0] g1 = hwdata_i & capability_register_2_i;
  wire [2:0] o0 = {pwm_unit_reset_o, hibernation_unit_reset_o,
    watchdog_unit_reset_o};
  wire [2:0] o1 = {comparator_2_reset_o, two_wire_unit_0_reset_o,
    async_serial_0_reset_o};
  // Marks the data phase of a register write
  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      w0_q <= 1'b0;
      w1_q <= 1'b0;
    end else begin
      w0_q <= take & hwrite_i & (idx == 10'h010);
      w1_q <= take & hwrite_i & (idx == 10'h011);
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_bus_okay: assert property (hreadyout_o & !hresp_o)
    else $error("slave not ready or not okay");
  a_reset_clear: assert property (disable iff (1'b0)
    rst_i |-> o0 == 3'h0 && o1 == 3'h0) else $error("request in reset");
  a_reg0_write: assert property (w0_q |=>
    o0 == $past({g0[20], g0[6], g0[3]})) else $error("request 0 write");
  a_reg1_write: assert property (w1_q |=>
    o1 == $past({g1[26], g1[12], g1[0]})) else $error("request 1 write");
  a_reg0_hold: assert property (!w0_q |=> $stable(o0))
    else $error("request 0 moved");
  a_reg1_hold: assert property (!w1_q |=> $stable(o1))
    else $error("request 1 moved");
  a_read_one: assert property (take & !hwrite_i & idx == 10'h011 |=>
    {hrdata_o[26], hrdata_o[12], hrdata_o[0]} == $past(o1))
    else $error("request 1 read");
  a_reserved_zero: assert property (take & !hwrite_i |=>
    (hrdata_o & 32'hF8E0_EE80) == 32'h0000_0000) else $error("reserved set");
endmodule // reset_ctrl_checker
bind peripheral_soft_reset_control reset_ctrl_checker
  reset_ctrl_checker_inst (.*);

/* peripheral_soft_reset_control_tb_top.sv */
// Random register traffic for the reset request block
`timescale 1ns/100ps
module peripheral_soft_reset_control_tb_top;
  reg ref_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg hsel_i = 1'b0;
  reg hwrite_i = 1'b0;
  reg [1:0] htrans_i = 2'h0;
  reg [2:0] hsize_i = 3'h2;
  reg [31:0] haddr_i = 0, hwdata_i = 0;
  reg [31:0] capability_register_1_i = 0, capability_register_2_i = 0;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hresp_o, pwm_unit_reset_o, hibernation_unit_reset_o,
    watchdog_unit_reset_o, comparator_0_reset_o, comparator_1_reset_o,
    comparator_2_reset_o, gp_counter_0_reset_o, gp_counter_1_reset_o,
    gp_counter_2_reset_o, gp_counter_3_reset_o, two_wire_unit_0_reset_o,
    quadrature_encoder_0_reset_o, sync_serial_0_reset_o,
    sync_serial_1_reset_o, async_serial_0_reset_o, async_serial_1_reset_o,
    async_serial_2_reset_o;
  wire hready_i = hreadyout_o;
  integer seed = 71165, miscompares = 0, samples_checked = 0, cyc = 0, i;
  reg [31:0] m0 = 0, m1 = 0, q, d, a, c1, c2;
  peripheral_soft_reset_control peripheral_soft_reset_control_inst (.*);
  initial forever #25 ref_clk_i = ~ref_clk_i;
  function [31:0] want(input [31:0] ad);
    want = ad[3:0] == 4'h0 ? m0 : ad[3:0] == 4'h4 ? m1 : 32'h0000_0000;
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: %h vs %h", $time, seen, exp);
      end
    end
  endtask
  task xfer(input w, input [31:0] ad, input [31:0] wd);
    begin
      @(posedge ref_clk_i);
      hsel_i <= 1'b1;
      haddr_i <= ad;
      hwrite_i <= w;
      htrans_i <= 2'h2;
      @(posedge ref_clk_i);
      while (hready_i !== 1'b1) @(posedge ref_clk_i);
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      @(posedge ref_clk_i);
      while (hready_i !== 1'b1) @(posedge ref_clk_i);
      q = hrdata_o;
    end
  endtask
  task print_verdict;
    begin
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Hang guard
  always @(posedge ref_clk_i) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 80; i = i + 1) begin
      // First pass all ones, second pass capabilities absent
      a = 32'h0000_0040 + 4 * ({$random(seed)} % 3);
      d = i < 2 ? 32'hFFFF_FFFF : $random(seed);
      c1 = i < 2 ? {32{i == 0}} : $random(seed);
      c2 = i < 2 ? {32{i == 0}} : $random(seed);
      capability_register_1_i <= c1;
      capability_register_2_i <= c2;
      if (i == 40) begin
        rst_i <= 1'b1;
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        m0 = 0;
        m1 = 0;
      end
      xfer(1'b0, a, 0);
      check(q, want(a));
      xfer(1'b1, a, d);
      if (a[3:0] == 4'h0) m0 = d & c1 & 32'h0010_0048;
      if (a[3:0] == 4'h4) m1 = d & c2 & 32'h070F_1137;
      xfer(1'b0, a, 0);
      check(q, want(a));
      check({pwm_unit_reset_o, hibernation_unit_reset_o,
        watchdog_unit_reset_o}, {m0[20], m0[6], m0[3]});
      check({comparator_2_reset_o, comparator_1_reset_o,
        comparator_0_reset_o, gp_counter_3_reset_o, gp_counter_2_reset_o,
        gp_counter_1_reset_o, gp_counter_0_reset_o, two_wire_unit_0_reset_o,
        quadrature_encoder_0_reset_o, sync_serial_1_reset_o,
        sync_serial_0_reset_o, async_serial_2_reset_o, async_serial_1_reset_o,
        async_serial_0_reset_o}, {m1[26:24], m1[19:16], m1[12], m1[8],
        m1[5:4], m1[2:0]});
    end
    // Read-modify-write writes reserved bits back as read
    capability_register_2_i <= 32'hFFFF_FFFF;
    xfer(1'b0, 32'h0000_0044, 0);
    d = q | 32'h0000_1000;
    xfer(1'b1, 32'h0000_0044, d);
    m1 = d & 32'h070F_1137;
    xfer(1'b0, 32'h0000_0044, 0);
    check(q, m1);
    check(two_wire_unit_0_reset_o, 1);
    print_verdict;
  end
endmodule // peripheral_soft_reset_control_tb_top
